// ===== hw/sic_pkg.sv
// package: constants and carriers for the script interrupt control block
// Functional notes
// - code 25 sets one interrupt enable
// - enable with number 255 sets global enable
// - code 26 clears one interrupt enable
// - disable with number 255 clears global enable
// - code 37 stores handler entry address
// - redefining a vector replaces old address
// - code 38 restores saved context
// - direct mode replies status 100, but status 6 for codes 37 and 38
// - nine byte frame, value msb first
package sic_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] SIC_CTRL_OFS = 12'h000;
    localparam logic [11:0] SIC_STAT_OFS = 12'h004;
    localparam logic [11:0] SIC_FRAME_LO_OFS = 12'h008;
    localparam logic [11:0] SIC_FRAME_MID_OFS = 12'h00C;
    localparam logic [11:0] SIC_FRAME_HI_OFS = 12'h010;
    localparam logic [11:0] SIC_REPLY_OFS = 12'h014;
    localparam logic [11:0] SIC_PC_OFS = 12'h018;
    localparam logic [11:0] SIC_ACCU_OFS = 12'h01C;
    localparam logic [11:0] SIC_XREG_OFS = 12'h020;
    localparam logic [11:0] SIC_FLAGS_OFS = 12'h024;
    localparam logic [11:0] SIC_IEN_OFS = 12'h028;
    // ctrl bits: 0 submit frame (self clearing), 1 standalone mode
    localparam int SIC_CTRL_GO_BIT = 0;
    localparam int SIC_CTRL_SA_BIT = 1;
    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    localparam logic [7:0] SIC_OP_ENABLE = 8'h19;
    localparam logic [7:0] SIC_OP_MASK = 8'h1A;
    localparam logic [7:0] SIC_OP_HANDLER_ENTRY_DEFINE_CMD = 8'h25;
    localparam logic [7:0] SIC_OP_RET = 8'h26;
    localparam logic [7:0] SIC_GLOBAL_NUM = 8'hFF;
    localparam logic [7:0] SIC_ST_OK = 8'h64;
    localparam logic [7:0] SIC_ST_BAD_SUM = 8'h01;
    localparam logic [7:0] SIC_ST_BAD_CMD = 8'h02;
    localparam logic [7:0] SIC_ST_BAD_MODE = 8'h06;
    localparam logic [31:0] SIC_ZERO_RST = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] instr;
        logic [7:0] typ;
        logic [7:0] bank;
        logic [31:0] value;
        logic [7:0] csum;
    } sic_frame_t;

    typedef struct packed {
        logic [31:0] pc;
        logic [31:0] accu;
        logic [31:0] xreg;
        logic [7:0] flags;
    } sic_ctx_t;
endpackage : sic_pkg

// ===== hw/sic_top.sv
// file: interrupt-control command interpreter with apb slave
`timescale 1ns/1ps
`default_nettype none
module sic_top #(
    parameter int NIRQ = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NIRQ-1:0] irq_in,
    output logic irq_taken
);
    localparam int AW = $clog2(NIRQ);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SIC_IDLE, SIC_EXEC, SIC_JUMP} sic_state_t;
    sic_state_t state_reg;
    sic_pkg::sic_frame_t frame_reg;
    sic_pkg::sic_ctx_t ctx_reg;
    sic_pkg::sic_ctx_t saved_reg;
    logic [NIRQ-1:0] ien_reg;
    logic [NIRQ-1:0] vdef_reg;
    logic [NIRQ-1:0] pend_reg;
    logic gen_reg;
    logic in_isr_reg;
    logic sa_reg;
    logic busy_reg;
    logic [7:0] status_reg;
    logic reply_valid_reg;
    logic [AW-1:0] irq_num_reg;

    logic [7:0] sum;
    logic [AW-1:0] num;
    logic is_global;
    logic num_ok;
    logic wr;
    logic rd;
    logic vec_we;
    logic [31:0] vec_rdata;
    logic [AW-1:0] vec_raddr;
    logic go;
    logic [NIRQ-1:0] ready_irq;
    logic [AW-1:0] pick;
    logic any_irq;

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~pwrite;
    assign go = wr && paddr == sic_pkg::SIC_CTRL_OFS
        && pwdata[sic_pkg::SIC_CTRL_GO_BIT] && !busy_reg;

    // ------------------------------------------------------------
    // frame checks
    // ------------------------------------------------------------
    assign sum = 8'(frame_reg.addr + frame_reg.instr + frame_reg.typ
        + frame_reg.bank + frame_reg.value[31:24] + frame_reg.value[23:16]
        + frame_reg.value[15:8] + frame_reg.value[7:0]);
    assign num = frame_reg.typ[AW-1:0];
    assign is_global = frame_reg.typ == sic_pkg::SIC_GLOBAL_NUM;
    assign num_ok = frame_reg.typ < 8'(NIRQ);
    assign vec_we = state_reg == SIC_EXEC && sum == frame_reg.csum
        && frame_reg.instr == sic_pkg::SIC_OP_HANDLER_ENTRY_DEFINE_CMD && num_ok
        && sa_reg;

    // ------------------------------------------------------------
    // interrupt selection: lowest pending, enabled and defined number wins
    // ------------------------------------------------------------
    assign ready_irq = pend_reg & ien_reg & vdef_reg;
    always_comb begin
        pick = '0;
        any_irq = 1'b0;
        for (int i = NIRQ - 1; i >= 0; i--) begin
            if (ready_irq[i]) begin
                pick = AW'(i);
                any_irq = 1'b1;
            end
        end
    end
    assign vec_raddr = pick;

    sic_vec_mem #(.AW(AW), .DW(32)) u_vec (
        .pclk(pclk),
        .we(vec_we),
        .waddr(num),
        .wdata(frame_reg.value),
        .raddr(vec_raddr),
        .rdata(vec_rdata)
    );

    // ------------------------------------------------------------
    // command sequencing
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SIC_IDLE;
            busy_reg <= 1'b0;
            irq_num_reg <= '0;
        end else begin
            case (state_reg)
                SIC_IDLE: begin
                    if (go) begin
                        state_reg <= SIC_EXEC;
                        busy_reg <= 1'b1;
                    end else if (gen_reg && !in_isr_reg && any_irq) begin
                        // vector read needs one cycle of memory latency
                        state_reg <= SIC_JUMP;
                        busy_reg <= 1'b1;
                        irq_num_reg <= pick;
                    end
                end
                SIC_EXEC: begin
                    state_reg <= SIC_IDLE;
                    busy_reg <= 1'b0;
                end
                SIC_JUMP: begin
                    state_reg <= SIC_IDLE;
                    busy_reg <= 1'b0;
                end
                default: begin
                    state_reg <= SIC_IDLE;
                    busy_reg <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // enables
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien_reg <= '0;
            gen_reg <= 1'b0;
        end else if (state_reg == SIC_EXEC && sum == frame_reg.csum) begin
            if (frame_reg.instr == sic_pkg::SIC_OP_ENABLE) begin
                if (is_global) begin
                    gen_reg <= 1'b1;
                end else if (num_ok) begin
                    ien_reg[num] <= 1'b1;
                end
            end else if (frame_reg.instr == sic_pkg::SIC_OP_MASK) begin
                if (is_global) begin
                    gen_reg <= 1'b0;
                end else if (num_ok) begin
                    ien_reg[num] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // vector defined flags and pending latches
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vdef_reg <= '0;
        end else if (vec_we) begin
            vdef_reg[num] <= 1'b1;
        end
    end

    // new event wins over the clear on dispatch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_reg <= '0;
        end else begin
            for (int i = 0; i < NIRQ; i++) begin
                if (irq_in[i]) begin
                    pend_reg[i] <= 1'b1;
                end else if (state_reg == SIC_JUMP && irq_num_reg == AW'(i)) begin
                    pend_reg[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // context save, dispatch, restore
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctx_reg <= '0;
            saved_reg <= '0;
            in_isr_reg <= 1'b0;
        end else if (state_reg == SIC_JUMP) begin
            saved_reg <= ctx_reg;
            ctx_reg.pc <= vec_rdata;
            in_isr_reg <= 1'b1;
        end else if (state_reg == SIC_EXEC && sum == frame_reg.csum
                && frame_reg.instr == sic_pkg::SIC_OP_RET && sa_reg
                && in_isr_reg) begin
            ctx_reg <= saved_reg;
            in_isr_reg <= 1'b0;
        end else if (wr && !busy_reg) begin
            case (paddr)
                sic_pkg::SIC_PC_OFS: ctx_reg.pc <= pwdata;
                sic_pkg::SIC_ACCU_OFS: ctx_reg.accu <= pwdata;
                sic_pkg::SIC_XREG_OFS: ctx_reg.xreg <= pwdata;
                sic_pkg::SIC_FLAGS_OFS: ctx_reg.flags <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    assign irq_taken = state_reg == SIC_JUMP;

    // ------------------------------------------------------------
    // reply and frame registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= 8'h00;
            reply_valid_reg <= 1'b0;
        end else if (state_reg == SIC_EXEC) begin
            reply_valid_reg <= 1'b1;
            if (sum != frame_reg.csum) begin
                status_reg <= sic_pkg::SIC_ST_BAD_SUM;
            end else if (frame_reg.instr != sic_pkg::SIC_OP_ENABLE
                    && frame_reg.instr != sic_pkg::SIC_OP_MASK
                    && frame_reg.instr != sic_pkg::SIC_OP_HANDLER_ENTRY_DEFINE_CMD
                    && frame_reg.instr != sic_pkg::SIC_OP_RET) begin
                status_reg <= sic_pkg::SIC_ST_BAD_CMD;
            end else if (!sa_reg && (frame_reg.instr == sic_pkg::SIC_OP_HANDLER_ENTRY_DEFINE_CMD
                    || frame_reg.instr == sic_pkg::SIC_OP_RET)) begin
                status_reg <= sic_pkg::SIC_ST_BAD_MODE;
            end else begin
                status_reg <= sic_pkg::SIC_ST_OK;
            end
        end else if (go) begin
            reply_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_reg <= '0;
            sa_reg <= 1'b0;
        end else if (wr && !busy_reg) begin
            case (paddr)
                // value bytes arrive msb first in the frame
                sic_pkg::SIC_FRAME_LO_OFS: {frame_reg.addr, frame_reg.instr,
                    frame_reg.typ, frame_reg.bank} <= pwdata;
                sic_pkg::SIC_FRAME_MID_OFS: frame_reg.value <= pwdata;
                sic_pkg::SIC_FRAME_HI_OFS: frame_reg.csum <= pwdata[7:0];
                sic_pkg::SIC_CTRL_OFS: sa_reg <= pwdata[sic_pkg::SIC_CTRL_SA_BIT];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // read mux, registered
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= sic_pkg::SIC_ZERO_RST;
        end else if (rd && !penable) begin
            case (paddr)
                sic_pkg::SIC_CTRL_OFS: prdata <= {30'h0, sa_reg, 1'b0};
                sic_pkg::SIC_STAT_OFS: prdata <= {20'h0, in_isr_reg, gen_reg,
                    busy_reg, reply_valid_reg, status_reg};
                sic_pkg::SIC_FRAME_LO_OFS: prdata <= {frame_reg.addr,
                    frame_reg.instr, frame_reg.typ, frame_reg.bank};
                sic_pkg::SIC_FRAME_MID_OFS: prdata <= frame_reg.value;
                sic_pkg::SIC_FRAME_HI_OFS: prdata <= {24'h0, frame_reg.csum};
                sic_pkg::SIC_REPLY_OFS: prdata <= {24'h0, status_reg};
                sic_pkg::SIC_PC_OFS: prdata <= ctx_reg.pc;
                sic_pkg::SIC_ACCU_OFS: prdata <= ctx_reg.accu;
                sic_pkg::SIC_XREG_OFS: prdata <= ctx_reg.xreg;
                sic_pkg::SIC_FLAGS_OFS: prdata <= {24'h0, ctx_reg.flags};
                sic_pkg::SIC_IEN_OFS: prdata <= 32'(ien_reg);
                default: prdata <= sic_pkg::SIC_ZERO_RST;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    global_on_a: assert property (state_reg == SIC_EXEC && sum == frame_reg.csum
        && frame_reg.instr == sic_pkg::SIC_OP_ENABLE && is_global |=> gen_reg)
        else $error("global enable not set");
    global_off_a: assert property (state_reg == SIC_EXEC && sum == frame_reg.csum
        && frame_reg.instr == sic_pkg::SIC_OP_MASK && is_global |=> !gen_reg)
        else $error("global enable not cleared");
    one_on_a: assert property (state_reg == SIC_EXEC && sum == frame_reg.csum
        && frame_reg.instr == sic_pkg::SIC_OP_ENABLE && num_ok
        |=> ien_reg[$past(num)])
        else $error("single enable not set");
    one_off_a: assert property (state_reg == SIC_EXEC && sum == frame_reg.csum
        && frame_reg.instr == sic_pkg::SIC_OP_MASK && num_ok
        |=> !ien_reg[$past(num)])
        else $error("single enable not cleared");
    handler_entry_define_cmd_def_a: assert property (vec_we |=> vdef_reg[$past(num)])
        else $error("vector not marked defined");
    ret_restore_a: assert property (state_reg == SIC_EXEC
        && sum == frame_reg.csum && frame_reg.instr == sic_pkg::SIC_OP_RET
        && sa_reg && in_isr_reg |=> ctx_reg == $past(saved_reg) && !in_isr_reg)
        else $error("context not restored");
    ok_reply_a: assert property (state_reg == SIC_EXEC && sum == frame_reg.csum
        && frame_reg.instr == sic_pkg::SIC_OP_ENABLE
        |=> status_reg == sic_pkg::SIC_ST_OK && reply_valid_reg)
        else $error("reply status wrong");
    bad_sum_a: assert property (state_reg == SIC_EXEC && sum != frame_reg.csum
        |=> status_reg == sic_pkg::SIC_ST_BAD_SUM && $stable(ien_reg))
        else $error("bad checksum executed");
    jump_pc_a: assert property (state_reg == SIC_JUMP
        |=> ctx_reg.pc == $past(vec_rdata) && in_isr_reg
        && state_reg == SIC_IDLE)
        else $error("dispatch did not jump");
    mode_a: assert property (state_reg == SIC_EXEC && sum == frame_reg.csum
        && !sa_reg && frame_reg.instr == sic_pkg::SIC_OP_HANDLER_ENTRY_DEFINE_CMD
        |-> !vec_we ##1 status_reg == sic_pkg::SIC_ST_BAD_MODE
        && $stable(vdef_reg))
        else $error("vector defined in direct mode");

    dispatch_c: cover property (irq_taken ##[1:50] state_reg == SIC_EXEC
        && frame_reg.instr == sic_pkg::SIC_OP_RET);
    global_c: cover property (gen_reg && any_irq);
    redef_c: cover property (vec_we && vdef_reg[num]);
endmodule : sic_top
`default_nettype wire

// ===== hw/sic_vec_mem.sv
// file: vector table memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module sic_vec_mem #(
    parameter int AW = 5,
    parameter int DW = 32
) (
    input wire logic pclk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : sic_vec_mem
`default_nettype wire

// ===== tb/sic_host.sv
// host model: apb master that builds and submits command frames
`timescale 1ns/1ps
`default_nettype none
module sic_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    output logic hung
);
    // ------------------------------------------------------------
    // apb transfer
    // ------------------------------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        hung = 1'b0;
    end

    // request held until pready seen high at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) hung <= 1'b1;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data no longer shows the last value
        pwdata <= ~d;
    endtask : xfer

    // ------------------------------------------------------------
    // command frame
    // ------------------------------------------------------------
    task automatic send(input logic [7:0] op, input logic [7:0] num,
                        input logic [31:0] val, input logic sa,
                        input logic bad, output logic [31:0] stat);
        logic [7:0] cs;
        logic [31:0] q;
        int n;
        cs = 8'h01 + op + num + 8'h00 + val[31:24];
        cs = cs + val[23:16] + val[15:8] + val[7:0];
        // corrupt sum only when a scenario asks for it
        if (bad) cs = ~cs;
        xfer(1'b1, sic_pkg::SIC_FRAME_LO_OFS, {8'h01, op, num, 8'h00}, q);
        xfer(1'b1, sic_pkg::SIC_FRAME_MID_OFS, val, q);
        xfer(1'b1, sic_pkg::SIC_FRAME_HI_OFS, {24'h00_0000, cs}, q);
        // sa marks a command issued by the stored program
        xfer(1'b1, sic_pkg::SIC_CTRL_OFS, {30'h0, sa, 1'b1}, q);
        n = 0;
        do begin
            xfer(1'b0, sic_pkg::SIC_STAT_OFS, 32'h0000_0000, q);
            n++;
        end while ((q[9] !== 1'b0 || q[8] !== 1'b1) && n < 20);
        if (q[9] !== 1'b0 || q[8] !== 1'b1) hung <= 1'b1;
        stat = q;
    endtask : send
endmodule : sic_host
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the interrupt control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] num;
        logic sa;
        logic [7:0] st;
        logic [31:0] ien;
        logic gen;
    } sic_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] irq_in = 32'h0000_0000;
    logic irq_taken;
    logic hung;
    logic [31:0] q;
    logic [11:0] ca [4];
    logic [31:0] cv [4];
    sic_row_t rows [10];
    int n_fail = 0;
    int checked = 0;
    int n_irq = 0;

    always #5 pclk = ~pclk;

    sic_top #(.NIRQ(32)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_in(irq_in),
        .irq_taken(irq_taken)
    );
    sic_host host_u (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .hung(hung)
    );

    always @(posedge pclk) begin
        if (irq_taken === 1'b1) n_irq <= n_irq + 1;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude;
        if (n_fail == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        host_u.xfer(1'b0, a, 32'h0000_0000, d);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        host_u.xfer(1'b1, a, d, x);
    endtask : wr

    // a stuck handshake ends the run as a failure
    always @(posedge hung) begin
        n_fail++;
        conclude();
    end

    initial begin
        #500000;
        n_fail++;
        conclude();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rows[0] = '{8'h19, 8'h03, 1'b0, 8'h64, 32'h0000_0008, 1'b0};
        rows[1] = '{8'h19, 8'hFF, 1'b0, 8'h64, 32'h0000_0008, 1'b1};
        rows[2] = '{8'h19, 8'h00, 1'b0, 8'h64, 32'h0000_0009, 1'b1};
        rows[3] = '{8'h1A, 8'h03, 1'b0, 8'h64, 32'h0000_0001, 1'b1};
        rows[4] = '{8'h1A, 8'hFF, 1'b0, 8'h64, 32'h0000_0001, 1'b0};
        rows[5] = '{8'h25, 8'h00, 1'b0, 8'h06, 32'h0000_0001, 1'b0};
        rows[6] = '{8'h26, 8'h00, 1'b0, 8'h06, 32'h0000_0001, 1'b0};
        rows[7] = '{8'h21, 8'h00, 1'b0, 8'h02, 32'h0000_0001, 1'b0};
        rows[8] = '{8'h19, 8'h28, 1'b0, 8'h64, 32'h0000_0001, 1'b0};
        rows[9] = '{8'h19, 8'hFF, 1'b1, 8'h64, 32'h0000_0001, 1'b1};
        ca = '{sic_pkg::SIC_PC_OFS, sic_pkg::SIC_ACCU_OFS,
               sic_pkg::SIC_XREG_OFS, sic_pkg::SIC_FLAGS_OFS};
        cv = '{32'h0000_0010, 32'h0000_00A5, 32'h0000_005A, 32'h0000_003C};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(sic_pkg::SIC_IEN_OFS, q);
        chk(q, 32'h0000_0000);
        rd(12'h0FC, q);
        chk(q, 32'h0000_0000);
        chk({31'h0, pslverr}, 32'h0000_0000);
        foreach (rows[i]) begin
            host_u.send(rows[i].op, rows[i].num, 32'h0, rows[i].sa, 1'b0, q);
            chk({24'h0, q[7:0]}, {24'h0, rows[i].st});
            chk({31'h0, q[10]}, {31'h0, rows[i].gen});
            rd(sic_pkg::SIC_IEN_OFS, q);
            chk(q, rows[i].ien);
        end
        // corrupted frame must leave the enables alone
        host_u.send(8'h19, 8'h05, 32'h0, 1'b0, 1'b1, q);
        chk({24'h0, q[7:0]}, 32'h0000_0001);
        rd(sic_pkg::SIC_IEN_OFS, q);
        chk(q, 32'h0000_0001);
        // vector defined, then replaced before use
        host_u.send(8'h25, 8'h00, 32'h0000_0032, 1'b1, 1'b0, q);
        chk({24'h0, q[7:0]}, 32'h0000_0064);
        rd(sic_pkg::SIC_REPLY_OFS, q);
        chk(q, 32'h0000_0064);
        host_u.send(8'h25, 8'h00, 32'h0000_0050, 1'b1, 1'b0, q);
        chk({24'h0, q[7:0]}, 32'h0000_0064);
        for (int k = 0; k < 4; k++) wr(ca[k], cv[k]);
        @(posedge pclk);
        irq_in <= 32'h0000_0001;
        @(posedge pclk);
        irq_in <= 32'h0000_0000;
        for (int k = 0; k < 20 && n_irq == 0; k++) @(posedge pclk);
        chk(32'(n_irq), 32'h0000_0001);
        rd(sic_pkg::SIC_PC_OFS, q);
        chk(q, 32'h0000_0050);
        rd(sic_pkg::SIC_STAT_OFS, q);
        chk({31'h0, q[11]}, 32'h0000_0001);
        // handler body clobbers the live context
        for (int k = 0; k < 4; k++) wr(ca[k], 32'h0000_0011);
        // handler ends with the return command, never falls through
        host_u.send(8'h26, 8'hFF, 32'h0, 1'b1, 1'b0, q);
        chk({24'h0, q[7:0]}, 32'h0000_0064);
        chk({31'h0, q[11]}, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            rd(ca[k], q);
            chk(q, cv[k]);
        end
        chk(32'(n_irq), 32'h0000_0001);
        // mid-run reset clears enables, status and context
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(sic_pkg::SIC_IEN_OFS, q);
        chk(q, 32'h0000_0000);
        rd(sic_pkg::SIC_STAT_OFS, q);
        chk(q, 32'h0000_0000);
        rd(sic_pkg::SIC_PC_OFS, q);
        chk(q, 32'h0000_0000);
        conclude();
    end
endmodule : tb
`default_nettype wire
